/* src/tmw_pkg.sv */
// Purpose: shared constants and types for the 16-bit waveform timer core
// Assumes: count clock arrives as a one-cycle enable from an outside prescaler
// Notes:   mode codes follow the 4-bit wave mode select encoding
package tmw_pkg;
	localparam logic [3:0] MODE_NORMAL  = 4'h0;
	localparam logic [3:0] MODE_PC8     = 4'h1;
	localparam logic [3:0] MODE_PC9     = 4'h2;
	localparam logic [3:0] MODE_PC10    = 4'h3;
	localparam logic [3:0] MODE_CTC_A   = 4'h4;
	localparam logic [3:0] MODE_FP8     = 4'h5;
	localparam logic [3:0] MODE_FP9     = 4'h6;
	localparam logic [3:0] MODE_FP10    = 4'h7;
	localparam logic [3:0] MODE_PFC_CAP = 4'h8;
	localparam logic [3:0] MODE_PFC_A   = 4'h9;
	localparam logic [3:0] MODE_PC_CAP  = 4'hA;
	localparam logic [3:0] MODE_PC_A    = 4'hB;
	localparam logic [3:0] MODE_CTC_CAP = 4'hC;
	localparam logic [3:0] MODE_FP_CAP  = 4'hE;
	localparam logic [3:0] MODE_FP_A    = 4'hF;
	localparam logic [15:0] TOP_8BIT    = 16'h00FF;
	localparam logic [15:0] TOP_9BIT    = 16'h01FF;
	localparam logic [15:0] TOP_10BIT   = 16'h03FF;
	localparam logic [15:0] TOP_MAX     = 16'hFFFF;
	localparam logic [15:0] BOTTOM      = 16'h0000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [1:0]  COM_OFF     = 2'h0;
	localparam logic [1:0]  COM_TOGGLE  = 2'h1;
	localparam logic [1:0]  COM_CLEAR   = 2'h2;
	localparam logic [1:0]  COM_SET     = 2'h3;
	localparam int          NUM_CH      = 2;

	typedef enum logic [1:0] {
		TMW_NORMAL = 2'b00,
		TMW_CTC    = 2'b01,
		TMW_FAST   = 2'b11,
		TMW_DUAL   = 2'b10
	} tmw_kind_t;

	// decoded view of the wave mode select
	typedef struct packed {
		tmw_kind_t   kind;
		logic        pfc;
		logic [15:0] top;
		logic        top_is_a;
	} tmw_mode_t;

	// per-channel configuration as seen by a compare unit
	typedef struct packed {
		logic [1:0]  output_mode;
		logic [15:0] buffered;
		logic        pin_dir_out;
	} tmw_chan_cfg_t;
endpackage

/* src/tmw_mode_decode.sv */
// Purpose: turns the wave mode select into counting kind and TOP value
// Assumes: capture and compare A values are stable across a count clock
// Notes:   purely combinational
`timescale 1ns/1ps
module tmw_mode_decode (
	input  wire logic [3:0]         wave_mode_select_i,
	input  wire logic [15:0]        capture_value_i,
	input  wire logic [15:0]        compare_a_value_i,
	output tmw_pkg::tmw_mode_t      mode_o
);
	always_comb begin
		mode_o.kind     = tmw_pkg::TMW_NORMAL;
		mode_o.pfc      = 1'b0;
		mode_o.top      = tmw_pkg::TOP_MAX;
		mode_o.top_is_a = 1'b0;
		case (wave_mode_select_i)
			tmw_pkg::MODE_CTC_A: begin
				mode_o.kind     = tmw_pkg::TMW_CTC;
				mode_o.top      = compare_a_value_i;
				mode_o.top_is_a = 1'b1;
			end
			tmw_pkg::MODE_CTC_CAP: begin
				mode_o.kind = tmw_pkg::TMW_CTC;
				mode_o.top  = capture_value_i;
			end
			tmw_pkg::MODE_FP8: begin
				mode_o.kind = tmw_pkg::TMW_FAST;
				mode_o.top  = tmw_pkg::TOP_8BIT;
			end
			tmw_pkg::MODE_FP9: begin
				mode_o.kind = tmw_pkg::TMW_FAST;
				mode_o.top  = tmw_pkg::TOP_9BIT;
			end
			tmw_pkg::MODE_FP10: begin
				mode_o.kind = tmw_pkg::TMW_FAST;
				mode_o.top  = tmw_pkg::TOP_10BIT;
			end
			tmw_pkg::MODE_FP_CAP: begin
				mode_o.kind = tmw_pkg::TMW_FAST;
				mode_o.top  = capture_value_i;
			end
			tmw_pkg::MODE_FP_A: begin
				mode_o.kind     = tmw_pkg::TMW_FAST;
				mode_o.top      = compare_a_value_i;
				mode_o.top_is_a = 1'b1;
			end
			tmw_pkg::MODE_PC8: begin
				mode_o.kind = tmw_pkg::TMW_DUAL;
				mode_o.top  = tmw_pkg::TOP_8BIT;
			end
			tmw_pkg::MODE_PC9: begin
				mode_o.kind = tmw_pkg::TMW_DUAL;
				mode_o.top  = tmw_pkg::TOP_9BIT;
			end
			tmw_pkg::MODE_PC10: begin
				mode_o.kind = tmw_pkg::TMW_DUAL;
				mode_o.top  = tmw_pkg::TOP_10BIT;
			end
			tmw_pkg::MODE_PC_CAP: begin
				mode_o.kind = tmw_pkg::TMW_DUAL;
				mode_o.top  = capture_value_i;
			end
			tmw_pkg::MODE_PC_A: begin
				mode_o.kind     = tmw_pkg::TMW_DUAL;
				mode_o.top      = compare_a_value_i;
				mode_o.top_is_a = 1'b1;
			end
			tmw_pkg::MODE_PFC_CAP: begin
				mode_o.kind = tmw_pkg::TMW_DUAL;
				mode_o.pfc  = 1'b1;
				mode_o.top  = capture_value_i;
			end
			tmw_pkg::MODE_PFC_A: begin
				mode_o.kind     = tmw_pkg::TMW_DUAL;
				mode_o.pfc      = 1'b1;
				mode_o.top      = compare_a_value_i;
				mode_o.top_is_a = 1'b1;
			end
			// undescribed codes fall back to plain counting
			default: begin
				mode_o.kind = tmw_pkg::TMW_NORMAL;
			end
		endcase
	end
endmodule

/* src/tmw_compare_unit.sv */
// Purpose: one output compare channel: active value, match and waveform
// Assumes: count_en_i is the one-cycle count clock enable
// Notes:   the active value is loaded on the load strobe in pwm kinds
`timescale 1ns/1ps
module tmw_compare_unit (
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  count_en_i,
	input  tmw_pkg::tmw_kind_t         kind_i,
	input  tmw_pkg::tmw_chan_cfg_t     cfg_i,
	input  wire logic [15:0]           count_i,
	input  wire logic [15:0]           next_count_i,
	input  wire logic [15:0]           top_i,
	input  wire logic                  down_i,
	input  wire logic                  load_i,
	input  wire logic                  start_i,
	output logic [15:0]                active_o,
	output logic                       match_o,
	output logic                       wave_o
);
	logic [15:0] next_active;
	logic        next_wave;
	logic        buffered_kind;
	logic        hit;

	// unbuffered kinds see software writes at once
	assign buffered_kind = (kind_i == tmw_pkg::TMW_FAST) ||
	                       (kind_i == tmw_pkg::TMW_DUAL);
	assign hit = (count_i == active_o);
	assign match_o = count_en_i && hit;

	always_comb begin
		next_active = active_o;
		next_wave   = wave_o;
		if (!buffered_kind) begin
			next_active = cfg_i.buffered;
		end else if (count_en_i && load_i) begin
			next_active = cfg_i.buffered;
		end
		if (count_en_i) begin
			case (kind_i)
				tmw_pkg::TMW_FAST: begin
					if (cfg_i.output_mode == tmw_pkg::COM_TOGGLE) begin
						if (hit) begin
							next_wave = ~wave_o;
						end
					end else if (cfg_i.output_mode != tmw_pkg::COM_OFF) begin
						// match beats the bottom update so compare equal to top stays flat
						if (hit) begin
							next_wave = (cfg_i.output_mode ==
							             tmw_pkg::COM_SET);
						end else if (next_count_i == tmw_pkg::BOTTOM) begin
							next_wave = (cfg_i.output_mode ==
							             tmw_pkg::COM_CLEAR);
						end
					end
				end
				tmw_pkg::TMW_DUAL: begin
					if (cfg_i.output_mode == tmw_pkg::COM_TOGGLE) begin
						if (hit) begin
							next_wave = ~wave_o;
						end
					end else if (cfg_i.output_mode != tmw_pkg::COM_OFF) begin
						if (hit && (active_o != top_i) &&
						    (active_o != tmw_pkg::BOTTOM)) begin
							next_wave = (down_i ^ (cfg_i.output_mode ==
							             tmw_pkg::COM_SET));
						end else if (load_i && (active_o == top_i) &&
						             (cfg_i.buffered != top_i)) begin
							next_wave = ~wave_o;
						end else if (start_i && (count_i > active_o)) begin
							next_wave = ~wave_o;
						end else if (active_o == top_i) begin
							next_wave = (cfg_i.output_mode ==
							             tmw_pkg::COM_CLEAR);
						end else if (active_o == tmw_pkg::BOTTOM) begin
							next_wave = (cfg_i.output_mode ==
							             tmw_pkg::COM_SET);
						end
					end
				end
				default: begin
					if (cfg_i.output_mode == tmw_pkg::COM_TOGGLE && hit) begin
						next_wave = ~wave_o;
					end else if (hit &&
					             cfg_i.output_mode != tmw_pkg::COM_OFF) begin
						next_wave = (cfg_i.output_mode == tmw_pkg::COM_SET);
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			active_o <= tmw_pkg::COUNT_RESET;
			wave_o   <= 1'b0;
		end else begin
			active_o <= next_active;
			wave_o   <= next_wave;
		end
	end
endmodule

/* src/tmw_core.sv */
// Purpose: 16-bit waveform timer core: counter, flags, two compare channels
// Assumes: count_en_i is a one-cycle pulse from the outside prescaler
// Notes:   flags are sticky; clear strobes lose to a same-cycle set
//
// Contract
// - codes 4 and 12 select clear-on-match
// - clear-on-match counts up, zero after TOP
// - match flag A sets when count reaches compare A (TOP in code 4)
// - clear-on-match compare writes apply immediately
// - wrap from max sets overflow flag
// - count clock comes from external prescaler
// - codes 5,6,7,14,15 select fast pwm
// - fast pwm counts zero to TOP, restarts
// - fast pwm: overflow and compare load at TOP
// - fast pwm: match clears, bottom sets output (mode 3 inverts)
// - compare zero spikes, compare TOP holds
// - toggle mode with A as TOP squares
// - codes 1,2,3,10,11 select phase-correct pwm
// - dual slope reverses at TOP and zero
// - phase-correct: overflow at zero, load at TOP
// - up match one level, down the other
// - forced toggles keep phase-correct waveform symmetric
// - codes 8 and 9 select phase-frequency-correct
// - phase-frequency-correct: overflow and load at zero
// - code 0 counts freely to 0xFFFF
// - output mode 1 toggles on match
`timescale 1ns/1ps
module tmw_core (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic        count_en_i,
	input  wire logic [3:0]  wave_mode_select_i,
	input  wire logic [15:0] capture_value_i,
	input  wire logic [15:0] compare_a_value_i,
	input  wire logic [15:0] compare_b_value_i,
	input  wire logic [1:0]  compare_a_output_mode_i,
	input  wire logic [1:0]  compare_b_output_mode_i,
	input  wire logic        pin_a_dir_out_i,
	input  wire logic        pin_b_dir_out_i,
	input  wire logic        count_write_i,
	input  wire logic [15:0] count_write_value_i,
	input  wire logic        overflow_clear_i,
	input  wire logic        match_a_clear_i,
	input  wire logic        match_b_clear_i,
	input  wire logic        overflow_irq_en_i,
	input  wire logic        match_a_irq_en_i,
	input  wire logic        match_b_irq_en_i,
	output logic [15:0]      count_value_o,
	output logic [15:0]      active_a_o,
	output logic [15:0]      active_b_o,
	output logic             overflow_flag_o,
	output logic             compare_a_match_flag_o,
	output logic             compare_b_match_flag_o,
	output logic             overflow_irq_o,
	output logic             compare_a_irq_o,
	output logic             compare_b_irq_o,
	output logic             compare_a_output_o,
	output logic             compare_b_output_o,
	output logic             compare_a_pin_o,
	output logic             compare_b_pin_o,
	output logic             count_down_o
);
	tmw_pkg::tmw_mode_t     mode;
	tmw_pkg::tmw_chan_cfg_t cfg [tmw_pkg::NUM_CH];
	logic [15:0]            count;
	logic [15:0]            next_count;
	logic                   down;
	logic                   next_down;
	logic                   started;
	logic                   next_started;
	logic                   ovf;
	logic                   next_ovf;
	logic [1:0]             mflag;
	logic [1:0]             next_mflag;
	logic [1:0]             match;
	logic [1:0]             wave;
	logic [15:0]            active [tmw_pkg::NUM_CH];
	logic [1:0]             next_pin;
	logic [1:0]             pin;
	logic [1:0]             irq;
	logic [1:0]             next_irq;
	logic                   ovf_irq;
	logic                   load;
	logic                   ovf_evt;
	logic                   at_top;
	logic                   at_bottom;
	logic [15:0]            top;

	tmw_mode_decode u_decode (
		.wave_mode_select_i (wave_mode_select_i),
		.capture_value_i    (capture_value_i),
		.compare_a_value_i  (compare_a_value_i),
		.mode_o             (mode)
	);

	// in pwm kinds with A as TOP the active copy governs the period
	assign top = (mode.top_is_a && mode.kind != tmw_pkg::TMW_CTC) ?
	             active[0] : mode.top;
	assign at_top    = (count == top);
	assign at_bottom = (count == tmw_pkg::BOTTOM);

	assign cfg[0] = '{output_mode: compare_a_output_mode_i,
	                  buffered: compare_a_value_i,
	                  pin_dir_out: pin_a_dir_out_i};
	assign cfg[1] = '{output_mode: compare_b_output_mode_i,
	                  buffered: compare_b_value_i,
	                  pin_dir_out: pin_b_dir_out_i};

	// counter, direction and the load/overflow event points
	always_comb begin
		next_count   = count;
		next_down    = down;
		next_started = started;
		load         = 1'b0;
		ovf_evt      = 1'b0;
		case (mode.kind)
			tmw_pkg::TMW_CTC: begin
				next_down = 1'b0;
				if (at_top) begin
					next_count = tmw_pkg::BOTTOM;
				end else begin
					next_count = count + 16'h0001;
				end
				// a TOP of 0xFFFF still wraps through zero and must flag it
				ovf_evt = (count == tmw_pkg::TOP_MAX);
			end
			tmw_pkg::TMW_FAST: begin
				next_down = 1'b0;
				if (count >= top) begin
					next_count = tmw_pkg::BOTTOM;
				end else begin
					next_count = count + 16'h0001;
				end
				load    = at_top;
				ovf_evt = at_top;
			end
			tmw_pkg::TMW_DUAL: begin
				if (count >= top) begin
					next_down  = 1'b1;
					next_count = (top == tmw_pkg::BOTTOM) ? top :
					             top - 16'h0001;
				end else if (at_bottom) begin
					next_down  = 1'b0;
					next_count = 16'h0001;
				end else if (down) begin
					next_count = count - 16'h0001;
				end else begin
					next_count = count + 16'h0001;
				end
				// top may move under a capture write; pfc relies on software
				load    = mode.pfc ? at_bottom : at_top;
				ovf_evt = at_bottom;
			end
			default: begin
				next_down  = 1'b0;
				next_count = count + 16'h0001;
				ovf_evt    = (count == tmw_pkg::TOP_MAX);
			end
		endcase
		if (!count_en_i) begin
			next_count = count;
			next_down  = down;
			load       = 1'b0;
			ovf_evt    = 1'b0;
		end else begin
			next_started = 1'b1;
		end
		if (count_write_i) begin
			next_count   = count_write_value_i;
			next_started = 1'b0;
		end
	end

	generate
		for (genvar i = 0; i < tmw_pkg::NUM_CH; i++) begin : g_ch
			tmw_compare_unit u_cmp (
				.ref_clk_i    (ref_clk_i),
				.rst_i        (rst_i),
				.count_en_i   (count_en_i),
				.kind_i       (mode.kind),
				.cfg_i        (cfg[i]),
				.count_i      (count),
				.next_count_i (next_count),
				.top_i        (top),
				.down_i       (down),
				.load_i       (load),
				.start_i      (!started),
				.active_o     (active[i]),
				.match_o      (match[i]),
				.wave_o       (wave[i])
			);
		end
	endgenerate

	// sticky flags: a set in the clear cycle wins
	always_comb begin
		next_ovf = ovf_evt || (ovf && !overflow_clear_i);
		next_mflag[0] = match[0] ||
		                (mflag[0] && !match_a_clear_i);
		next_mflag[1] = match[1] || (mflag[1] && !match_b_clear_i);
		next_irq[0] = next_mflag[0] && match_a_irq_en_i;
		next_irq[1] = next_mflag[1] && match_b_irq_en_i;
		for (int i = 0; i < tmw_pkg::NUM_CH; i++) begin
			next_pin[i] = wave[i] && cfg[i].pin_dir_out;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			count   <= tmw_pkg::COUNT_RESET;
			down    <= 1'b0;
			started <= 1'b0;
			ovf     <= 1'b0;
			mflag   <= 2'h0;
			irq     <= 2'h0;
			ovf_irq <= 1'b0;
			pin     <= 2'h0;
		end else begin
			count   <= next_count;
			down    <= next_down;
			started <= next_started;
			ovf     <= next_ovf;
			mflag   <= next_mflag;
			irq     <= next_irq;
			ovf_irq <= next_ovf && overflow_irq_en_i;
			pin     <= next_pin;
		end
	end

	// output ports mirror flip-flops directly
	assign count_value_o          = count;
	assign active_a_o             = active[0];
	assign active_b_o             = active[1];
	assign overflow_flag_o        = ovf;
	assign compare_a_match_flag_o = mflag[0];
	assign compare_b_match_flag_o = mflag[1];
	assign overflow_irq_o         = ovf_irq;
	assign compare_a_irq_o        = irq[0];
	assign compare_b_irq_o        = irq[1];
	assign compare_a_output_o     = wave[0];
	assign compare_b_output_o     = wave[1];
	assign compare_a_pin_o        = pin[0];
	assign compare_b_pin_o        = pin[1];
	assign count_down_o           = down;
endmodule

/* verification/tmw_cpu_model.sv */
// Purpose: count clock source standing in for the outside prescaler
// Assumes: div_i holds 1, 8, 64, 256 or 1024
// Notes:   a one-cycle enable every div_i system clocks
`timescale 1ns/1ps
module tmw_cpu_model (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic [10:0] div_i,
	output logic             count_en_o
);
	logic [10:0] cnt;
	logic [10:0] next_cnt;
	logic        next_en;

	always_comb begin
		next_cnt = cnt + 11'h001;
		// a lowered divider must not strand the counter above it
		if (next_cnt >= div_i) begin
			next_cnt = 11'h000;
		end
		next_en = next_cnt == 11'h000;
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			cnt <= 11'h000;
			count_en_o <= 1'b0;
		end else begin
			cnt <= next_cnt;
			count_en_o <= next_en;
		end
	end
endmodule

/* verification/tmw_core_monitor.sv */
// Purpose: port checks on the waveform timer core
// Assumes: one clock domain, synchronous active-high reset
// Notes:   count write cycles and cycles right after a mode or compare A change are skipped
`timescale 1ns/1ps
module tmw_core_monitor (
	input wire logic        ref_clk_i,
	input wire logic        rst_i,
	input wire logic        count_en_i,
	input wire logic        count_write_i,
	input wire logic [3:0]  wave_mode_select_i,
	input wire logic [15:0] compare_a_value_i,
	input wire logic        pin_a_dir_out_i,
	input wire logic [15:0] count_value_o,
	input wire logic [15:0] active_a_o,
	input wire logic        overflow_flag_o,
	input wire logic        compare_a_match_flag_o,
	input wire logic        compare_a_output_o,
	input wire logic        compare_a_pin_o,
	input wire logic        count_down_o
);
	logic [3:0]  prev_mode;
	logic [15:0] prev_a;
	logic        ok;
	logic        clear_on_match_mode;
	logic        fp8;
	logic        pc8;
	logic        pfc;

	always_ff @(posedge ref_clk_i) begin
		prev_mode <= wave_mode_select_i;
		prev_a <= compare_a_value_i;
	end

	assign ok = count_en_i && !count_write_i && prev_a == compare_a_value_i
		&& prev_mode == wave_mode_select_i;
	assign clear_on_match_mode = ok && wave_mode_select_i == tmw_pkg::MODE_CTC_A;
	assign fp8 = ok && wave_mode_select_i == tmw_pkg::MODE_FP8;
	assign pc8 = ok && wave_mode_select_i == tmw_pkg::MODE_PC8;
	assign pfc = ok && wave_mode_select_i == tmw_pkg::MODE_PFC_CAP;

	default clocking dc @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	a_ctc_step_up: assert property (
		clear_on_match_mode && count_value_o != compare_a_value_i
		|=> count_value_o == $past(count_value_o) + 16'h0001)
		else $error("ctc count did not step");
	a_ctc_clear_top: assert property (
		clear_on_match_mode && count_value_o == compare_a_value_i |=> count_value_o == 16'h0)
		else $error("ctc count not cleared at top");
	a_ctc_match_flag: assert property (
		clear_on_match_mode && count_value_o == compare_a_value_i |=> compare_a_match_flag_o)
		else $error("ctc match flag missing");
	a_ctc_wrap_ovf: assert property (
		clear_on_match_mode && count_value_o == 16'hFFFF
		|=> overflow_flag_o && count_value_o == 16'h0)
		else $error("wrap overflow missing");
	a_fast_top_ovf: assert property (
		fp8 && count_value_o == 16'h00FF
		|=> overflow_flag_o && count_value_o == 16'h0)
		else $error("fast top restart wrong");
	a_fast_load_top: assert property (
		fp8 && count_value_o == 16'h00FF
		|=> active_a_o == $past(compare_a_value_i))
		else $error("fast load at top missing");
	a_dual_top_turn: assert property (
		pc8 && count_value_o == 16'h00FF
		|=> count_value_o == 16'h00FE && count_down_o)
		else $error("dual turn at top wrong");
	a_dual_bot_ovf: assert property (
		pc8 && count_value_o == 16'h0
		|=> count_value_o == 16'h0001 && overflow_flag_o && !count_down_o)
		else $error("dual bottom wrong");
	a_pc_load_top: assert property (
		pc8 && count_value_o == 16'h00FF
		|=> active_a_o == $past(compare_a_value_i))
		else $error("pc load at top missing");
	a_pfc_load_bot: assert property (
		pfc && count_value_o == 16'h0
		|=> active_a_o == $past(compare_a_value_i) && overflow_flag_o)
		else $error("pfc bottom load missing");
	a_pin_gate: assert property (
		compare_a_pin_o == $past(compare_a_output_o && pin_a_dir_out_i))
		else $error("pin a not gated");

	c_ctc_top: cover property (clear_on_match_mode && count_value_o == compare_a_value_i);
	c_fast_top: cover property (fp8 && count_value_o == 16'h00FF);
	c_pfc_bot: cover property (pfc && count_value_o == 16'h0);
endmodule

bind tmw_core tmw_core_monitor i_mon (.*);

/* verification/testbench.sv */
// Purpose: self-checking bench for the waveform timer core
// Assumes: prescale 1 unless a scenario sets div
// Notes:   high times are counted in samples of one count clock
`timescale 1ns/1ps
module testbench;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [10:0] div = 11'h001;
	logic [3:0]  mode = 4'h0;
	logic [15:0] cap = 16'h0030;
	logic [15:0] ca = 16'h0020;
	logic [15:0] cb = 16'h0040;
	logic [15:0] wval = 16'h0000;
	logic [1:0]  ma = 2'h0;
	logic [1:0]  mb = 2'h0;
	logic        da = 1'b1;
	logic        wr = 1'b0;
	logic        ovc = 1'b0;
	logic        mac = 1'b0;
	logic [15:0] cnt, act_a, act_b;
	logic        en, ovf, mfa, mfb, ovi, mai, mbi, oa, ob, pa, pb, dn;
	int          n_errors = 0;
	int          check_count = 0;

	always #4 clk = ~clk;

	tmw_cpu_model i_cpu (.ref_clk_i(clk), .rst_i(rst), .div_i(div),
		.count_en_o(en));

	tmw_core i_dut (.ref_clk_i(clk), .rst_i(rst), .count_en_i(en),
		.wave_mode_select_i(mode), .capture_value_i(cap),
		.compare_a_value_i(ca), .compare_b_value_i(cb),
		.compare_a_output_mode_i(ma), .compare_b_output_mode_i(mb),
		.pin_a_dir_out_i(da), .pin_b_dir_out_i(1'b0),
		.count_write_i(wr), .count_write_value_i(wval),
		.overflow_clear_i(ovc), .match_a_clear_i(mac),
		.match_b_clear_i(1'b0), .overflow_irq_en_i(1'b1),
		.match_a_irq_en_i(1'b1), .match_b_irq_en_i(1'b1),
		.count_value_o(cnt), .active_a_o(act_a), .active_b_o(act_b),
		.overflow_flag_o(ovf), .compare_a_match_flag_o(mfa),
		.compare_b_match_flag_o(mfb), .overflow_irq_o(ovi),
		.compare_a_irq_o(mai), .compare_b_irq_o(mbi),
		.compare_a_output_o(oa), .compare_b_output_o(ob),
		.compare_a_pin_o(pa), .compare_b_pin_o(pb), .count_down_o(dn));

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input string nm, input logic [15:0] got,
		input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic finish_test();
		if (n_errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// a write of the count keeps a lowered top from running to 0xFFFF
	task automatic setm(input logic [3:0] m, input logic [15:0] v);
		{mode, wr, wval, ovc, mac} = {m, 1'b1, v, 2'b11};
		step(1);
		{wr, ovc, mac} = 3'b000;
	endtask

	task automatic meas(input bit sb, output int p, output int h);
		int i;
		i = 0;
		p = 0;
		h = 0;
		while (cnt !== 16'h0000 && i < 5000) begin
			step(1);
			i++;
		end
		do begin
			h += int'((sb ? ob : oa) === 1'b1);
			step(1);
			p++;
		end while (cnt !== 16'h0000 && p < 5000);
	endtask

	task automatic tog(output int n);
		logic o0;
		o0 = oa;
		n = 0;
		while (oa === o0 && n < 5000) begin
			step(1);
			n++;
		end
	endtask

	task automatic t_periods();
		logic [3:0]  m[14] = '{4'h4, 4'hC, 4'h5, 4'h6, 4'h7, 4'hE, 4'hF,
			4'h1, 4'h2, 4'h3, 4'hA, 4'hB, 4'h9, 4'h8};
		logic [15:0] t[14] = '{16'h20, 16'h30, 16'hFF, 16'h1FF, 16'h3FF,
			16'h30, 16'h20, 16'hFF, 16'h1FF, 16'h3FF, 16'h30, 16'h20,
			16'h20, 16'h30};
		int p;
		int h;
		// top only rises across the pfc codes, never falls
		for (int i = 0; i < 14; i++) begin
			setm(m[i], 16'h0000);
			meas(0, p, h);
			chk("period", 16'(p), i < 7 ? t[i] + 16'h0001
				: {t[i][14:0], 1'b0});
			if (i >= 2) begin
				chk("overflow irq", 16'(ovi), 16'h0001);
			end
		end
	endtask

	task automatic t_ctc();
		int n;
		setm(4'h4, 16'h0000);
		{ca, ma} = {16'h0002, 2'h1};
		for (int k = 0; k < 3; k++) begin
			div = 11'(1 << (3 * k));
			tog(n);
			tog(n);
			chk("ctc toggle gap", 16'(n), 16'(3 << (3 * k)));
		end
		chk("match irq", 16'(mai), 16'h0001);
		mac = 1'b1;
		step(1);
		mac = 1'b0;
		step(3);
		chk("match cleared", 16'(mfa), 16'h0000);
	endtask

	task automatic t_late();
		int p;
		int h;
		{div, ca} = {11'h001, 16'h0010};
		setm(4'h4, 16'hFFF0);
		step(16);
		chk("wrap count", cnt, 16'h0000);
		chk("early match", 16'(mfa), 16'h0000);
		chk("wrap overflow", 16'(ovf), 16'h0001);
		meas(0, p, h);
		chk("ctc period", 16'(p), 16'h0011);
		chk("late match", 16'(mfa), 16'h0001);
	endtask

	task automatic t_fast();
		logic [15:0] v[3] = '{16'h0040, 16'h0000, 16'h00FF};
		logic [15:0] old;
		int p;
		int h;
		mb = 2'h2;
		setm(4'h5, 16'h0000);
		for (int i = 0; i < 3; i++) begin
			step(16);
			old = act_b;
			cb = v[i];
			step(2);
			chk("b buffered", act_b, old);
			meas(1, p, h);
			chk("fast high", 16'(h), i == 0 ? 16'h0041 : i == 1 ? 16'h0001
				: 16'(h == 256 ? 256 : 0));
			chk("b active", act_b, v[i]);
		end
		chk("pin b gated", 16'(pb), 16'h0000);
		chk("match b irq", 16'(mbi), 16'h0001);
		chk("match b flag", 16'(mfb), 16'h0001);
	endtask

	task automatic t_square();
		int p;
		int h;
		int h2;
		{ca, ma} = {16'h0020, 2'h1};
		setm(4'hF, 16'h0000);
		// first period still runs on the old active top
		meas(0, p, h);
		meas(0, p, h);
		meas(0, p, h2);
		chk("square period", 16'(p), 16'h0021);
		chk("square high", 16'(h + h2), 16'h0021);
		da = 1'b0;
		step(2);
		chk("pin a off", 16'(pa), 16'h0000);
		da = 1'b1;
	endtask

	task automatic t_dual();
		logic [15:0] v[4] = '{16'h0040, 16'h0000, 16'h00FF, 16'h0040};
		logic        w0;
		int p;
		int h;
		setm(4'h1, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			cb = v[i];
			meas(1, p, h);
			meas(1, p, h);
			chk("dual high", 16'(h), v[i] == 16'h0040 ? 16'h0080
				: 16'(h == 510 ? 510 : 0));
		end
		// restart above compare B so the up match is missed
		w0 = ob;
		setm(4'h1, 16'h0080);
		step(1);
		chk("forced toggle", 16'(ob), {15'h0000, ~w0});
	endtask

	initial begin
		step(10);
		rst = 1'b0;
		t_periods();
		t_ctc();
		t_late();
		t_fast();
		t_square();
		t_dual();
		finish_test();
	end

	initial begin
		#400000;
		n_errors++;
		finish_test();
	end
endmodule
